// >>> ctb_pkg.sv
package ctb_pkg;

    // ------------------------------------------------------------
    // register map (wishbone byte addresses, 32-bit words)
    // ------------------------------------------------------------
    localparam int CTB_ADR_W = 16;
    localparam logic [15:0] CTB_ADDR_CTRL = 16'h8020;
    localparam logic [15:0] CTB_ADDR_STATUS = 16'h8024;
    localparam logic [15:0] CTB_ADDR_MASK = 16'h8028;
    localparam logic [15:0] CTB_ADDR_STATE = 16'h802c;
    localparam logic [15:0] CTB_ADDR_STROBES = 16'h8030;

    // ------------------------------------------------------------
    // control byte fields
    // ------------------------------------------------------------
    localparam int CTB_CTRL_TRACE_EN_BIT = 3;
    localparam int CTB_CTRL_BLINK_BIT = 5;
    localparam int CTB_CTRL_CLEAR_BIT = 7;
    localparam logic [7:0] CTB_CTRL_RESET = 8'h00;

    // ------------------------------------------------------------
    // interrupt status / mask fields
    // ------------------------------------------------------------
    localparam int CTB_IRQ_W = 3;
    localparam int CTB_IRQ_OVF_BIT = 0;
    localparam int CTB_IRQ_BOUND_BIT = 1;
    localparam int CTB_IRQ_WCLR_BIT = 2;
    localparam logic [2:0] CTB_STATUS_RESET = 3'h0;
    localparam logic [2:0] CTB_MASK_RESET = 3'h0;

    // ------------------------------------------------------------
    // state register fields (read only)
    // ------------------------------------------------------------
    localparam int CTB_ST_BLANK_BIT = 0;
    localparam int CTB_ST_WINDOW_BIT = 1;
    localparam int CTB_ST_XY_FF_BIT = 2;
    localparam int CTB_ST_OVF_BIT = 3;
    localparam int CTB_ST_XY_MODE_N_BIT = 4;
    localparam int CTB_ST_DOT_JOIN_BIT = 5;

    // ------------------------------------------------------------
    // decode values and misc
    // ------------------------------------------------------------
    localparam logic [7:0] CTB_BOUNDARY_ADDR = 8'hfd;
    localparam int CTB_STROBE_CNT_W = 16;
    localparam int CTB_SYNC_STAGES = 2;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [15:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } ctb_wb_req_t;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } ctb_wb_rsp_t;

    typedef struct packed {
        logic data_field_select;
        logic field_write;
        logic [7:0] field_addr;
        logic xy_address_lsb;
        logic xy_mode_n;
        logic overflow_pulse;
        logic dot_join_blink;
    } ctb_pins_t;

    localparam int CTB_PINS_W = 14;

    typedef enum logic [1:0] {
        CTB_BUS_IDLE = 2'b01,
        CTB_BUS_ACK = 2'b10
    } ctb_bus_state_t;

    typedef struct packed {
        ctb_bus_state_t bus;
        logic ack;
        logic [31:0] rdata;
        logic [7:0] ctrl;
        logic [2:0] status;
        logic [2:0] mask;
        logic irq;
        logic strobe_prev;
        logic sweep_window;
        logic xy_ff;
        logic ovf_flag;
        logic blank;
        logic [15:0] strobes;
    } ctb_core_state_t;

    localparam ctb_core_state_t CTB_CORE_RESET = '{
        bus: CTB_BUS_IDLE,
        ack: 1'b0,
        rdata: 32'h0000_0000,
        ctrl: CTB_CTRL_RESET,
        status: CTB_STATUS_RESET,
        mask: CTB_MASK_RESET,
        irq: 1'b0,
        strobe_prev: 1'b0,
        sweep_window: 1'b0,
        xy_ff: 1'b0,
        ovf_flag: 1'b0,
        blank: 1'b1,
        strobes: 16'h0000
    };

endpackage : ctb_pkg

// >>> ctb_sync.sv
`timescale 1ns/1ps
module ctb_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    import ctb_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } ctb_sync_state_t;

    ctb_sync_state_t s;
    ctb_sync_state_t next_s;

    // first stage feeds only the second
    always_comb begin
        next_s.stage1 = async_in;
        next_s.stage2 = s.stage1;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign sync_out = s.stage2;

endmodule : ctb_sync

// >>> ctb_blank.sv
//Behaviour
// - beam_blank_out high blanks the trace, low lets it show.
// - blank output is NAND of all conditions; trace only when all high.
// - trace_enable high only while a stored memory is displayed.
// - overflow pulse captured in a flip-flop on data-field write strobe.
// - captured overflow ORed with overload blink so trace blinks slowly.
// - dot_join_blink is one blanking condition, blanking periodically.
// - address FDH on low eight address lines marks sweep boundary.
// - boundary detect loaded into sweep-window flip-flop on each data strobe.
// - trace blanked whenever sweep window is low.
// - software sweep-window clear resets that flip-flop, blanking the trace.
// - in XY mode a second flip-flop gives the xy_blank condition.
// - xy flip-flop loads xy_address_lsb only on data-field write strobe.
// - control byte write latches trace enable, overload blink and clear.
// - sweep-window clear is bit 7 of the control byte.
// - overload blink is bit 5 of the control byte.
//
// The address map and register access over Wishbone were chosen for this implementation.
`timescale 1ns/1ps
module ctb_blank (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire ctb_pkg::ctb_wb_req_t wb_req,
    output ctb_pkg::ctb_wb_rsp_t wb_rsp,
    input wire ctb_pkg::ctb_pins_t pins_async,
    output logic beam_blank_out,
    output logic sweep_window,
    output logic irq
);
    import ctb_pkg::*;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    function automatic logic reg_hit(input logic [15:0] adr, input logic [15:0] base);
        reg_hit = (adr[15:2] == base[15:2]);
    endfunction : reg_hit

    function automatic logic is_boundary(input logic [7:0] low_addr);
        is_boundary = (low_addr == CTB_BOUNDARY_ADDR);
    endfunction : is_boundary

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [CTB_PINS_W-1:0] pins_sync_vec;
    ctb_pins_t pins;

    ctb_sync #(
        .WIDTH(CTB_PINS_W)
    ) u_pin_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .async_in(pins_async),
        .sync_out(pins_sync_vec)
    );

    assign pins = ctb_pins_t'(pins_sync_vec);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    ctb_core_state_t s;
    ctb_core_state_t next_s;

    logic strobe_lvl;
    logic strobe;
    logic boundary;
    logic bus_req;
    logic wr_accept;
    logic rd_accept;
    logic [2:0] events;
    logic [2:0] w1c;
    logic cond_trace;
    logic cond_ovl;
    logic cond_dot;
    logic cond_window;
    logic cond_xy;
    logic [31:0] rd_value;

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        next_s = s;
        w1c = 3'h0;
        rd_value = 32'h0000_0000;

        // data-field write strobe, edge of select and write together
        strobe_lvl = pins.data_field_select & pins.field_write;
        strobe = strobe_lvl & ~s.strobe_prev;
        next_s.strobe_prev = strobe_lvl;
        boundary = is_boundary(pins.field_addr);

        // wishbone classic: one ack per request, dropped next cycle
        bus_req = wb_req.cyc & wb_req.stb;
        wr_accept = 1'b0;
        rd_accept = 1'b0;
        case (s.bus)
            CTB_BUS_IDLE: begin
                if (bus_req) begin
                    next_s.ack = 1'b1;
                    next_s.bus = CTB_BUS_ACK;
                    wr_accept = wb_req.we;
                    rd_accept = ~wb_req.we;
                end else begin
                    next_s.ack = 1'b0;
                end
            end
            CTB_BUS_ACK: begin
                next_s.ack = 1'b0;
                next_s.bus = CTB_BUS_IDLE;
            end
            default: begin
                next_s.ack = 1'b0;
                next_s.bus = CTB_BUS_IDLE;
            end
        endcase

        // register writes, low byte lane only
        if (wr_accept && wb_req.sel[0]) begin
            if (reg_hit(wb_req.adr, CTB_ADDR_CTRL)) begin
                next_s.ctrl = wb_req.dat[7:0];
            end
            if (reg_hit(wb_req.adr, CTB_ADDR_STATUS)) begin
                w1c = wb_req.dat[CTB_IRQ_W-1:0];
            end
            if (reg_hit(wb_req.adr, CTB_ADDR_MASK)) begin
                next_s.mask = wb_req.dat[CTB_IRQ_W-1:0];
            end
        end

        // flip-flops clocked by the data-field strobe
        if (strobe) begin
            next_s.sweep_window = boundary;
            next_s.xy_ff = pins.xy_address_lsb;
            next_s.ovf_flag = pins.overflow_pulse;
            next_s.strobes = s.strobes + 16'h0001;
        end

        // clear dominates the load, held while the control bit stays set
        if (next_s.ctrl[CTB_CTRL_CLEAR_BIT]) begin
            next_s.sweep_window = 1'b0;
        end

        // sticky events, set wins over a same-cycle clear
        events = 3'h0;
        events[CTB_IRQ_OVF_BIT] = strobe & pins.overflow_pulse;
        events[CTB_IRQ_BOUND_BIT] = strobe & boundary;
        events[CTB_IRQ_WCLR_BIT] = s.sweep_window & ~next_s.sweep_window & next_s.ctrl[CTB_CTRL_CLEAR_BIT];
        next_s.status = (s.status & ~w1c) | events;
        next_s.irq = |(next_s.status & next_s.mask);

        // blanking conditions, each high lets the trace through
        cond_trace = next_s.ctrl[CTB_CTRL_TRACE_EN_BIT];
        cond_ovl = ~next_s.ovf_flag | next_s.ctrl[CTB_CTRL_BLINK_BIT];
        cond_dot = pins.dot_join_blink;
        cond_window = next_s.sweep_window;
        cond_xy = pins.xy_mode_n ? 1'b1 : next_s.xy_ff;
        next_s.blank = ~(cond_trace & cond_ovl & cond_dot & cond_window & cond_xy);

        // read mux, unmapped reads return zero
        if (reg_hit(wb_req.adr, CTB_ADDR_CTRL)) begin
            rd_value[7:0] = s.ctrl;
        end else if (reg_hit(wb_req.adr, CTB_ADDR_STATUS)) begin
            rd_value[CTB_IRQ_W-1:0] = s.status;
        end else if (reg_hit(wb_req.adr, CTB_ADDR_MASK)) begin
            rd_value[CTB_IRQ_W-1:0] = s.mask;
        end else if (reg_hit(wb_req.adr, CTB_ADDR_STATE)) begin
            rd_value[CTB_ST_BLANK_BIT] = s.blank;
            rd_value[CTB_ST_WINDOW_BIT] = s.sweep_window;
            rd_value[CTB_ST_XY_FF_BIT] = s.xy_ff;
            rd_value[CTB_ST_OVF_BIT] = s.ovf_flag;
            rd_value[CTB_ST_XY_MODE_N_BIT] = pins.xy_mode_n;
            rd_value[CTB_ST_DOT_JOIN_BIT] = pins.dot_join_blink;
        end else if (reg_hit(wb_req.adr, CTB_ADDR_STROBES)) begin
            rd_value[CTB_STROBE_CNT_W-1:0] = s.strobes;
        end
        if (rd_accept) begin
            next_s.rdata = rd_value;
        end else if (s.bus == CTB_BUS_ACK) begin
            next_s.rdata = 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s <= CTB_CORE_RESET;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // outputs, all straight from flops
    // ------------------------------------------------------------
    assign wb_rsp.ack = s.ack;
    assign wb_rsp.dat = s.rdata;
    assign beam_blank_out = s.blank;
    assign sweep_window = s.sweep_window;
    assign irq = s.irq;

endmodule : ctb_blank

// >>> ctb_blank_sva.sv
`timescale 1ns/1ps
module ctb_blank_sva (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire ctb_pkg::ctb_wb_req_t wb_req,
    input wire ctb_pkg::ctb_wb_rsp_t wb_rsp,
    input wire ctb_pkg::ctb_pins_t pins_async,
    input wire logic beam_blank_out,
    input wire logic sweep_window,
    input wire logic irq
);
    import ctb_pkg::*;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // ----
    // shadow of the control byte
    // ----
    logic [7:0] ctrl_q;
    logic take, wr_ctrl, strobe, fd_ok, eb;
    assign take = wb_req.cyc && wb_req.stb && !wb_rsp.ack;
    assign wr_ctrl = take && wb_req.we && wb_req.sel[0] && wb_req.adr == CTB_ADDR_CTRL;
    assign strobe = pins_async.data_field_select && pins_async.field_write;
    assign fd_ok = pins_async.field_addr == CTB_BOUNDARY_ADDR && !ctrl_q[7];
    // valid only while pins hold across the strobe
    assign eb = !(ctrl_q[3] && (!pins_async.overflow_pulse || ctrl_q[5]) && pins_async.dot_join_blink
        && fd_ok && (pins_async.xy_mode_n || pins_async.xy_address_lsb));
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ctrl_q <= 8'h00;
        end else if (wr_ctrl) begin
            ctrl_q <= wb_req.dat[7:0];
        end
    end
    a_ack_next: assert property (take |=> wb_rsp.ack) else $error("no ack after request");
    a_ack_single: assert property (wb_rsp.ack |=> !wb_rsp.ack) else $error("ack longer than one cycle");
    a_reset_blank: assert property ($rose(rst_n) |-> beam_blank_out && !sweep_window && !irq)
        else $error("outputs not at reset values");
    a_window_blank: assert property (!sweep_window |-> beam_blank_out) else $error("trace shown, window low");
    a_clear_window: assert property (wr_ctrl && wb_req.dat[7] |=> !sweep_window)
        else $error("clear bit left window set");
    a_trace_off: assert property (wr_ctrl && !wb_req.dat[3] |=> beam_blank_out)
        else $error("trace shown while disabled");
    a_strobe_window: assert property ($rose(strobe) |-> ##3 sweep_window == $past(fd_ok, 3))
        else $error("window load wrong");
    a_strobe_blank: assert property ($rose(strobe) |-> ##3 beam_blank_out == $past(eb, 3))
        else $error("blank decision wrong");
    c_ovf: cover property ($rose(strobe) && pins_async.overflow_pulse);
    c_xy: cover property ($rose(strobe) && !pins_async.xy_mode_n);
    c_irq: cover property ($rose(irq));
endmodule : ctb_blank_sva
bind ctb_blank ctb_blank_sva u_sva (.clk_sys(clk_sys), .rst_n(rst_n), .wb_req(wb_req), .wb_rsp(wb_rsp),
    .pins_async(pins_async), .beam_blank_out(beam_blank_out), .sweep_window(sweep_window), .irq(irq));

// >>> ctb_field_model.sv
`timescale 1ns/1ps
module ctb_field_model (
    input wire logic clk_sys,
    output ctb_pkg::ctb_pins_t pins
);
    import ctb_pkg::*;
    initial begin
        pins = '{1'b0, 1'b0, 8'h00, 1'b0, 1'b1, 1'b0, 1'b1};
    end
    // ----
    // one data-field write, slow adds setup and width
    // ----
    task automatic frame(input logic [7:0] a, input logic ov, input logic lsb, input logic xymn, input logic dj,
        input int slow);
        @(posedge clk_sys);
        pins.field_addr <= a;
        pins.overflow_pulse <= ov;
        pins.xy_address_lsb <= lsb;
        pins.xy_mode_n <= xymn;
        pins.dot_join_blink <= dj;
        repeat (3 + slow) @(posedge clk_sys);
        pins.data_field_select <= 1'b1;
        pins.field_write <= 1'b1;
        repeat (2 + slow) @(posedge clk_sys);
        pins.data_field_select <= 1'b0;
        pins.field_write <= 1'b0;
        repeat (3) @(posedge clk_sys);
        // released lines must not look held
        pins.field_addr <= ~a;
        pins.overflow_pulse <= 1'b0;
        pins.xy_address_lsb <= ~lsb;
    endtask : frame
endmodule : ctb_field_model

// >>> ctb_blank_test.sv
`timescale 1ns/1ps
module ctb_blank_test;
    import ctb_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    ctb_wb_req_t wb_req = '0;
    ctb_wb_rsp_t wb_rsp;
    ctb_pins_t pins;
    logic beam_blank_out, sweep_window, irq;
    logic [34:0] expq[$];
    int bad_count = 0;
    int checks_done = 0;
    logic [7:0] ctrl = 8'h00;
    logic [2:0] status = 3'h0;
    logic [2:0] mask = 3'h0;
    logic sw = 1'b0, ovf = 1'b0, xyff = 1'b0, xymn = 1'b1, dj = 1'b1;
    logic [15:0] strobes = 16'h0000;
    always #4 clk_sys = ~clk_sys;
    ctb_blank u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .wb_req(wb_req), .wb_rsp(wb_rsp), .pins_async(pins),
        .beam_blank_out(beam_blank_out), .sweep_window(sweep_window), .irq(irq));
    ctb_field_model u_far (.clk_sys(clk_sys), .pins(pins));
    // ----
    // tasks
    // ----
    task automatic check(input logic [34:0] seen, input logic [34:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wrap_up;
        $display("mismatches %0d comparisons %0d", bad_count, checks_done);
        if (bad_count == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : wrap_up
    task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        wb_req <= '{1'b1, 1'b1, w, a, 4'h1, d};
        do begin
            @(posedge clk_sys);
            n++;
        end while (wb_rsp.ack !== 1'b1 && n < 50);
        wb_req <= '0;
        if (wb_rsp.ack !== 1'b1) begin
            bad_count++;
            wrap_up();
        end
    endtask : bus
    function automatic logic [34:0] exp_state();
        logic b;
        b = !(ctrl[3] && (!ovf || ctrl[5]) && dj && sw && (xymn || xyff));
        return {|(status & mask), sw, b, 26'h0, dj, xymn, ovf, xyff, sw, b};
    endfunction : exp_state
    task automatic rd(input logic [15:0] a, input logic [31:0] v);
        logic [34:0] e;
        e = exp_state();
        expq.push_back({e[34:32], (a == CTB_ADDR_STATE) ? e[31:0] : v});
        bus(1'b0, a, 32'h0);
    endtask : rd
    task automatic wctrl(input logic [7:0] d);
        status[2] = status[2] | (d[7] & sw);
        sw = sw & !d[7];
        ctrl = d;
        bus(1'b1, CTB_ADDR_CTRL, {24'h0, d});
    endtask : wctrl
    task automatic frm(input logic [7:0] a, input logic ov, input logic lsb, input logic m, input logic j);
        u_far.frame(a, ov, lsb, m, j, $urandom % 3);
        xymn = m;
        dj = j;
        ovf = ov;
        xyff = lsb;
        sw = (a == CTB_BOUNDARY_ADDR) && !ctrl[7];
        status = status | {1'b0, a == CTB_BOUNDARY_ADDR, ov};
        strobes = strobes + 16'h0001;
    endtask : frm
    always @(posedge clk_sys) begin
        if (rst_n && wb_rsp.ack === 1'b1 && !wb_req.we) begin
            check({irq, sweep_window, beam_blank_out, wb_rsp.dat}, expq.pop_front());
        end
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        bad_count++;
        wrap_up();
    end
    // ----
    // main sequence
    // ----
    initial begin
        int i;
        void'($urandom(32'h9783));
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(CTB_ADDR_CTRL, 32'h0);
        rd(CTB_ADDR_STATE, 32'h0);
        rd(16'h8040, 32'h0);
        wctrl(8'h08);
        for (i = 0; i < 16; i++) begin
            if (i == 9 || i == 12) wctrl(8'h28);
            if (i == 11) wctrl(8'h88);
            if (i == 15) wctrl(8'h20);
            frm((i % 4 != 0) ? CTB_BOUNDARY_ADDR : 8'($urandom), i % 4 == 2, i[2], i % 5 != 3, i != 5);
            rd(CTB_ADDR_STATE, 32'h0);
            rd(CTB_ADDR_STATUS, {29'h0, status});
        end
        rd(CTB_ADDR_STROBES, {16'h0000, strobes});
        // unmapped write must leave every register alone
        bus(1'b1, 16'h8040, 32'h0000_00ff);
        rd(CTB_ADDR_CTRL, {24'h000000, ctrl});
        mask = 3'h7;
        bus(1'b1, CTB_ADDR_MASK, 32'h7);
        rd(CTB_ADDR_MASK, 32'h7);
        mask = 3'h0;
        bus(1'b1, CTB_ADDR_MASK, 32'h0);
        rd(CTB_ADDR_STATE, 32'h0);
        mask = 3'h4;
        bus(1'b1, CTB_ADDR_MASK, 32'h4);
        status = status & 3'h4;
        bus(1'b1, CTB_ADDR_STATUS, 32'h3);
        rd(CTB_ADDR_STATUS, {29'h0, status});
        status = 3'h0;
        bus(1'b1, CTB_ADDR_STATUS, 32'h4);
        rd(CTB_ADDR_STATUS, 32'h0);
        // mid-run reset, pins keep their last levels
        rst_n <= 1'b0;
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        ctrl = 8'h00;
        status = 3'h0;
        mask = 3'h0;
        sw = 1'b0;
        ovf = 1'b0;
        xyff = 1'b0;
        strobes = 16'h0000;
        // first read goes to a register, state read waits for the synchronisers
        rd(CTB_ADDR_STROBES, 32'h0);
        rd(CTB_ADDR_CTRL, 32'h0);
        rd(CTB_ADDR_STATE, 32'h0);
        wrap_up();
    end
endmodule : ctb_blank_test
